//--- pcg_axil_slave.sv
/*
  AXI4-Lite slave front end: takes one write and one read at a time,
  hands a one-cycle access strobe to the register file and returns its
  answer. Assumes the register file answers combinationally.
*/
`timescale 1ns/1ps

module pcg_axil_slave
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // Write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // Read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Register file side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_err
);

  // Holding registers for each channel
  logic              aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic              w_hold_reg,  w_hold_next;
  logic [DATA_W-1:0] w_data_reg,  w_data_next;
  logic [3:0]        w_strb_reg,  w_strb_next;
  logic              ar_hold_reg, ar_hold_next;
  logic [ADDR_W-1:0] ar_addr_reg, ar_addr_next;
  // Registered bus outputs
  logic              awready_reg, awready_next;
  logic              wready_reg,  wready_next;
  logic              arready_reg, arready_next;
  logic              bvalid_reg,  bvalid_next;
  logic [1:0]        bresp_reg,   bresp_next;
  logic              rvalid_reg,  rvalid_next;
  logic [1:0]        rresp_reg,   rresp_next;
  logic [DATA_W-1:0] rdata_reg,   rdata_next;

  // Write strobe fires once both halves are held, read strobe once the address is; neither while its answer pends
  assign wr_en   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign wr_strb = w_strb_reg;
  assign rd_en   = ar_hold_reg && !rvalid_reg;
  assign rd_addr = ar_addr_reg;

  // Next-state logic for all channels
  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next  = w_hold_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    ar_hold_next = ar_hold_reg;
    ar_addr_next = ar_addr_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    // Address and data taken in either order
    if (s_axi_awvalid && awready_reg)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    // Write performed, response raised
    if (wr_en)
    begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    // Read address
    if (s_axi_arvalid && arready_reg)
    begin
      ar_hold_next = 1'b1;
      ar_addr_next = s_axi_araddr;
    end
    // Read data captured while the address is held
    if (rd_en)
    begin
      ar_hold_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = rd_data;
      rresp_next   = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    // Ready only while the channel is empty and nothing pends
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next  = !w_hold_next && !bvalid_next;
    arready_next = !ar_hold_next && !rvalid_next;
  end

  // Register stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= 4'h0;
      ar_hold_reg <= 1'b0;
      ar_addr_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      ar_hold_reg <= ar_hold_next;
      ar_addr_reg <= ar_addr_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

endmodule // pcg_axil_slave

//--- pcg_pkg.sv
/*
  Shared constants for the peripheral clock gating block: register map,
  field positions, writable masks, reset values, unit indices and modes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package pcg_pkg;

  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_RUN_CLOCK_CONFIG = 12'h060;
  localparam logic [11:0] OFS_GATE_FIRST       = 12'h100;
  localparam logic [11:0] OFS_RUN_GATE_SECOND  = 12'h108;
  localparam logic [11:0] OFS_SLEEP_GATE_SEC   = 12'h118;
  localparam logic [11:0] OFS_DEEP_GATE_SEC    = 12'h128;
  localparam logic [11:0] OFS_IRQ_STATUS       = 12'h140;
  localparam logic [11:0] OFS_IRQ_ENABLE       = 12'h144;
  localparam logic [11:0] OFS_IRQ_CLEAR        = 12'h148;
  localparam logic [11:0] OFS_GATE_STATE       = 12'h14c;

  // First gating register fields
  localparam int BIT_TIMER_ZERO_GATE      = 16;
  localparam int BIT_I2C_MODULE_ONE_GATE  = 14;
  localparam int BIT_I2C_MODULE_ZERO_GATE = 12;
  localparam int BIT_SYNC_SERIAL_ZERO     = 4;
  localparam int BIT_UART_ZERO_GATE       = 0;

  // Second gating register fields
  localparam int BIT_MICRO_DMA_GATE = 13;
  localparam int BIT_PORT_E_GATE    = 4;
  localparam int BIT_PORT_A_GATE    = 0;

  // Clock configuration field
  localparam int BIT_AUTO_GATING_SELECT = 0;

  // Writable bits; everything else is reserved, reads zero
  localparam logic [31:0] MASK_GATE_FIRST  = 32'h0001_5011;
  localparam logic [31:0] MASK_GATE_SECOND = 32'h0000_201f;
  localparam logic [31:0] MASK_CLOCK_CFG   = 32'h0000_0001;
  localparam logic [31:0] MASK_IRQ         = 32'h0000_0003;

  // Reset values
  localparam logic [31:0] RESET_GATE = 32'h0000_0000;
  localparam logic [31:0] RESET_CFG  = 32'h0000_0000;

  // Gated units: index into the clock enable vector
  localparam int NUM_UNITS        = 11;
  localparam int UNIT_TIMER_ZERO  = 0;
  localparam int UNIT_I2C_ONE     = 1;
  localparam int UNIT_I2C_ZERO    = 2;
  localparam int UNIT_SYNC_SERIAL = 3;
  localparam int UNIT_UART_ZERO   = 4;
  localparam int UNIT_MICRO_DMA   = 5;
  localparam int UNIT_PORT_A      = 6;  // ports A..E at 6..10

  // Interrupt status bits
  localparam int IRQ_ACCESS_FAULT = 0;
  localparam int IRQ_MODE_CHANGE  = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b10
  } pcg_mode_type;

endpackage

//--- pcg_top.sv
/*
  Peripheral clock gating controller: per-unit clock enables chosen from
  run, sleep or deep-sleep gating registers, bus fault on access to an
  unclocked unit, sticky event status with one interrupt line.
  Assumes an external glitch-free clock gate cell per unit driven by
  unit_clk_en, and a power manager giving sleep and deep-sleep levels.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// - Gate bit one clocks unit, zero disables
// - Access to unclocked unit answers bus fault
// - All gate bits reset to zero
// - Run, sleep, deep copies apply per mode
// - Sleep copies used only with auto gating
// - Reserved bits read zero, ignore writes
// - Second register: DMA bit 13, ports 4..0
// - First register: timer, I2C, serial, UART bits
// - Run second register at offset 0x108
// - Sleep copy at offset 0x118
// - Deep-sleep copy at offset 0x128
module pcg_top
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Power mode requests, levels
  input  wire logic                 sleep_mode,
  input  wire logic                 deep_sleep_mode,
  // Peripheral access check
  input  wire logic                 unit_access,
  input  wire logic [3:0]           unit_select,
  output logic                      unit_access_ok,
  output logic                      unit_bus_fault,
  // Unit clock enables
  output logic [NUM_UNITS-1:0]      unit_clk_en,
  // Interrupt
  output logic                      irq
);

  // Register file strobes from the bus front end
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;

  // Software-visible registers
  logic [31:0] clock_cfg_reg,  clock_cfg_next;   // Auto gating select
  logic [31:0] gate_first_reg, gate_first_next;  // First gating register
  logic [31:0] run_gate_second_reg,  run_gate_second_next;
  logic [31:0] sleep_gate_second_reg, sleep_gate_second_next;
  logic [31:0] deep_gate_second_reg, deep_gate_second_next;
  logic [31:0] status_reg, status_next;          // Sticky events
  logic [31:0] enable_reg, enable_next;          // Interrupt mask

  // Block state
  pcg_mode_type           mode_reg, mode_next;   // Current power mode
  logic [NUM_UNITS-1:0]   clk_en_reg, clk_en_next;
  logic                   ok_reg, ok_next;
  logic                   fault_reg, fault_next;
  logic                   irq_reg, irq_next;

  // Decoded events and selections
  pcg_mode_type           mode_now;
  logic [31:0]            second_sel;
  logic [NUM_UNITS-1:0]   unit_en_sel;
  logic                   access_fault;
  logic [31:0]            clear_bits;
  logic [31:0]            event_bits;

  // Byte-lane merge, masked to the writable bits
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_write = ((old_val & ~lanes) | (new_val & lanes)) & mask;
  endfunction

  // Address hits the given register, for a write or a read
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [11:0]       ofs
  );
    hit = (addr == ofs);
  endfunction

  // Bus front end
  pcg_axil_slave pcg_axil_slave_inst (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Power mode and gate selection; deep sleep outranks sleep
  always_comb
  begin
    if (deep_sleep_mode)
      mode_now = MODE_DEEP;
    else if (sleep_mode)
      mode_now = MODE_SLEEP;
    else
      mode_now = MODE_RUN;
    second_sel = run_gate_second_reg;
    if (clock_cfg_reg[BIT_AUTO_GATING_SELECT])
    begin
      unique case (mode_now)
        MODE_SLEEP: second_sel = sleep_gate_second_reg;
        MODE_DEEP:  second_sel = deep_gate_second_reg;
        MODE_RUN:   second_sel = run_gate_second_reg;
        default:    second_sel = run_gate_second_reg;
      endcase
    end
    // First register has no sleep copies; it holds in all modes
    unit_en_sel[UNIT_TIMER_ZERO]  = gate_first_reg[BIT_TIMER_ZERO_GATE];
    unit_en_sel[UNIT_I2C_ONE]     = gate_first_reg[BIT_I2C_MODULE_ONE_GATE];
    unit_en_sel[UNIT_I2C_ZERO]    = gate_first_reg[BIT_I2C_MODULE_ZERO_GATE];
    unit_en_sel[UNIT_SYNC_SERIAL] = gate_first_reg[BIT_SYNC_SERIAL_ZERO];
    unit_en_sel[UNIT_UART_ZERO]   = gate_first_reg[BIT_UART_ZERO_GATE];
    unit_en_sel[UNIT_MICRO_DMA]   = second_sel[BIT_MICRO_DMA_GATE];
    unit_en_sel[UNIT_PORT_A +: 5] =
      second_sel[BIT_PORT_E_GATE:BIT_PORT_A_GATE];
  end

  // Register write path and decode errors
  always_comb
  begin
    clock_cfg_next        = clock_cfg_reg;
    gate_first_next       = gate_first_reg;
    run_gate_second_next  = run_gate_second_reg;
    sleep_gate_second_next = sleep_gate_second_reg;
    deep_gate_second_next = deep_gate_second_reg;
    enable_next           = enable_reg;
    clear_bits            = 32'h0000_0000;
    wr_err                = 1'b0;
    if (wr_en)
    begin
      // Masks keep reserved bits at zero whatever software writes
      if (hit(wr_addr, OFS_RUN_CLOCK_CONFIG))
        clock_cfg_next = merge_write(clock_cfg_reg, wr_data, wr_strb,
                                     MASK_CLOCK_CFG);
      else if (hit(wr_addr, OFS_GATE_FIRST))
        gate_first_next = merge_write(gate_first_reg, wr_data, wr_strb,
                                      MASK_GATE_FIRST);
      else if (hit(wr_addr, OFS_RUN_GATE_SECOND))
        run_gate_second_next = merge_write(run_gate_second_reg, wr_data,
                                           wr_strb, MASK_GATE_SECOND);
      else if (hit(wr_addr, OFS_SLEEP_GATE_SEC))
        sleep_gate_second_next = merge_write(sleep_gate_second_reg,
                                             wr_data, wr_strb,
                                             MASK_GATE_SECOND);
      else if (hit(wr_addr, OFS_DEEP_GATE_SEC))
        deep_gate_second_next = merge_write(deep_gate_second_reg, wr_data,
                                            wr_strb, MASK_GATE_SECOND);
      else if (hit(wr_addr, OFS_IRQ_ENABLE))
        enable_next = merge_write(enable_reg, wr_data, wr_strb, MASK_IRQ);
      else if (hit(wr_addr, OFS_IRQ_CLEAR))
        clear_bits = merge_write(32'h0000_0000, wr_data, wr_strb, MASK_IRQ);
      else
        wr_err = 1'b1;  // Unmapped or read-only
    end
  end

  // Read mux; reserved bits come back zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rd_en)
    begin
      if (hit(rd_addr, OFS_RUN_CLOCK_CONFIG))
        rd_data = clock_cfg_reg;
      else if (hit(rd_addr, OFS_GATE_FIRST))
        rd_data = gate_first_reg;
      else if (hit(rd_addr, OFS_RUN_GATE_SECOND))
        rd_data = run_gate_second_reg;
      else if (hit(rd_addr, OFS_SLEEP_GATE_SEC))
        rd_data = sleep_gate_second_reg;
      else if (hit(rd_addr, OFS_DEEP_GATE_SEC))
        rd_data = deep_gate_second_reg;
      else if (hit(rd_addr, OFS_IRQ_STATUS))
        rd_data = status_reg;
      else if (hit(rd_addr, OFS_IRQ_ENABLE))
        rd_data = enable_reg;
      else if (hit(rd_addr, OFS_GATE_STATE))
        rd_data = {14'h0000, mode_reg, 5'h00, clk_en_reg};
      else
        rd_err = 1'b1;  // Clear register is write-only
    end
  end

  // Access check, events, status and interrupt
  always_comb
  begin
    // Selector beyond the last unit is treated as unclocked
    access_fault = unit_access &&
                   ((unit_select >= 4'(NUM_UNITS)) ||
                    !clk_en_reg[unit_select]);
    ok_next      = unit_access && !access_fault;
    fault_next   = access_fault;
    mode_next    = mode_now;
    event_bits   = 32'h0000_0000;
    event_bits[IRQ_ACCESS_FAULT] = access_fault;
    event_bits[IRQ_MODE_CHANGE]  = (mode_now != mode_reg);
    // Set wins over a clear in the same cycle
    status_next  = ((status_reg & ~clear_bits) | event_bits) & MASK_IRQ;
    irq_next     = |(status_next & enable_next);
    // Enables change only at a clock edge, so the cell sees no glitch
    clk_en_next  = unit_en_sel;
  end

  // Register stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_cfg_reg         <= RESET_CFG;
      gate_first_reg        <= RESET_GATE;
      run_gate_second_reg   <= RESET_GATE;
      sleep_gate_second_reg <= RESET_GATE;
      deep_gate_second_reg  <= RESET_GATE;
      status_reg            <= 32'h0000_0000;
      enable_reg            <= 32'h0000_0000;
      mode_reg              <= MODE_RUN;
      clk_en_reg            <= '0;
      ok_reg                <= 1'b0;
      fault_reg             <= 1'b0;
      irq_reg               <= 1'b0;
    end
    else
    begin
      clock_cfg_reg         <= clock_cfg_next;
      gate_first_reg        <= gate_first_next;
      run_gate_second_reg   <= run_gate_second_next;
      sleep_gate_second_reg <= sleep_gate_second_next;
      deep_gate_second_reg  <= deep_gate_second_next;
      status_reg            <= status_next;
      enable_reg            <= enable_next;
      mode_reg              <= mode_next;
      clk_en_reg            <= clk_en_next;
      ok_reg                <= ok_next;
      fault_reg             <= fault_next;
      irq_reg               <= irq_next;
    end
  end

  // Outputs straight from flip-flops
  assign unit_clk_en    = clk_en_reg;
  assign unit_access_ok = ok_reg;
  assign unit_bus_fault = fault_reg;
  assign irq            = irq_reg;

endmodule // pcg_top

//--- pcg_top_properties.sv
/*
  Port-level checker for the clock gating block: access verdicts,
  reset state of the enables, bus answer timing and holding.
  Assumes it is bound onto pcg_top and sees only its ports.
*/
`timescale 1ns/1ps

module pcg_top_properties
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Bus handshakes and answers
  input wire logic                 s_axi_awvalid, s_axi_awready,
  input wire logic                 s_axi_wvalid, s_axi_wready,
  input wire logic                 s_axi_bvalid, s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_arvalid, s_axi_arready,
  input wire logic                 s_axi_rvalid, s_axi_rready,
  input wire logic [DATA_W-1:0]    s_axi_rdata,
  // Unit side
  input wire logic                 unit_access,
  input wire logic [3:0]           unit_select,
  input wire logic                 unit_access_ok, unit_bus_fault,
  input wire logic [NUM_UNITS-1:0] unit_clk_en,
  input wire logic                 irq
);
  // Padded so selects past the last unit read as gated
  logic [15:0] en_wide;
  logic        hit;
  logic        miss;
  assign en_wide = {5'h00, unit_clk_en};
  assign hit     = unit_access && en_wide[unit_select];
  assign miss    = unit_access && !en_wide[unit_select];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  grant_clocked_a: assert property (hit |=> unit_access_ok && !unit_bus_fault)
    else $error("access to clocked unit not granted");
  fault_gated_a: assert property (miss |=> unit_bus_fault && !unit_access_ok)
    else $error("access to gated unit not faulted");
  pulse_cause_a: assert property ((unit_access_ok || unit_bus_fault) |->
    $past(unit_access)) else $error("verdict without an access");
  reset_clear_a: assert property ($rose(aresetn) |-> unit_clk_en == '0 && !irq)
    else $error("enables or irq not clear after reset");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:3] s_axi_rvalid) else $error("read answer late");

  // Main scenarios reached
  cover property (miss ##1 unit_bus_fault);
  cover property (hit ##1 unit_access_ok);
  cover property ($rose(irq));
endmodule // pcg_top_properties

bind pcg_top pcg_top_properties pcg_top_properties_inst (.*);

//--- pcg_top_test.sv
/*
  Self-checking bench for the clock gating block over AXI4-Lite.
  Assumes pcg_top, the unit model and the bound checker.
*/
`timescale 1ns/1ps

module pcg_top_test
  import pcg_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, unit_select;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic sleep_mode = 0, deep_sleep_mode = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, unit_access, unit_access_ok, unit_bus_fault, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_UNITS-1:0] unit_clk_en;
  int err_count = 0, n_compared = 0, cyc = 0;

  pcg_top pcg_top_inst (.*);
  pcg_unit_model pcg_unit_model_inst (.aclk(aclk), .unit_access(unit_access),
    .unit_select(unit_select));

  initial forever #5 aclk = ~aclk;

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin err_count++; print_verdict(); end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw = 1, w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 0;
      if (s_axi_wready) w = 0;
      s_axi_awvalid <= aw; s_axi_wvalid <= w;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Enables follow one edge after their cause; two edges leave margin
  task automatic en_is(input logic [10:0] e);
    repeat (2) @(posedge aclk);
    #1 chk(32'(unit_clk_en), 32'(e));
  endtask

  task automatic acc(input logic [3:0] s, input logic ok);
    pcg_unit_model_inst.touch(s);
    #1 chk({30'h0, unit_access_ok, unit_bus_fault}, {30'h0, ok, !ok});
  endtask

  task automatic t_reset;
    rdc(OFS_GATE_FIRST, 32'h0, RESP_OKAY);
    rdc(OFS_RUN_GATE_SECOND, 32'h0, RESP_OKAY);
    rdc(OFS_SLEEP_GATE_SEC, 32'h0, RESP_OKAY);
    rdc(OFS_DEEP_GATE_SEC, 32'h0, RESP_OKAY);
    en_is(11'h000);
    acc(4'h0, 1'b0);
  endtask

  task automatic t_fields;
    wr(OFS_RUN_GATE_SECOND, 32'hffff_ffff, RESP_OKAY);
    rdc(OFS_RUN_GATE_SECOND, 32'h0000_201f, RESP_OKAY);
    en_is(11'h7e0);
    wr(OFS_GATE_FIRST, 32'hffff_ffff, RESP_OKAY);
    rdc(OFS_GATE_FIRST, 32'h0001_5011, RESP_OKAY);
    en_is(11'h7ff);
    for (int i = 0; i < NUM_UNITS; i++) acc(4'(i), 1'b1);
    acc(4'hb, 1'b0);
  endtask

  task automatic t_irq;
    wr(OFS_IRQ_CLEAR, 32'h3, RESP_OKAY);
    wr(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY);
    wr(OFS_RUN_GATE_SECOND, 32'h0000_2000, RESP_OKAY);
    en_is(11'h03f);
    acc(4'h6, 1'b0);
    @(posedge aclk); #1 chk(32'(irq), 32'h1);
    rdc(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
    @(posedge aclk); #1 chk(32'(irq), 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
    acc(4'h7, 1'b0);
    @(posedge aclk); #1 chk(32'(irq), 32'h0);
    rdc(12'h200, 32'h0, RESP_SLVERR);
    wr(OFS_IRQ_STATUS, 32'h1, RESP_SLVERR);
    wr(OFS_IRQ_CLEAR, 32'h3, RESP_OKAY);
  endtask

  task automatic t_modes;
    wr(OFS_GATE_FIRST, 32'h0, RESP_OKAY);
    wr(OFS_RUN_GATE_SECOND, 32'h1, RESP_OKAY);
    wr(OFS_SLEEP_GATE_SEC, 32'h2, RESP_OKAY);
    wr(OFS_DEEP_GATE_SEC, 32'h4, RESP_OKAY);
    sleep_mode <= 1;
    en_is(11'h040);
    deep_sleep_mode <= 1;
    en_is(11'h040);
    wr(OFS_RUN_CLOCK_CONFIG, 32'h1, RESP_OKAY);
    en_is(11'h100);
    deep_sleep_mode <= 0;
    en_is(11'h080);
    rdc(OFS_GATE_STATE, 32'h0001_0080, RESP_OKAY);
    acc(4'h6, 1'b0);
    sleep_mode <= 0;
    en_is(11'h040);
    acc(4'h7, 1'b0);
    rdc(OFS_IRQ_STATUS, 32'h3, RESP_OKAY);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_fields();
    t_irq();
    t_modes();
    print_verdict();
  end
endmodule // pcg_top_test

//--- pcg_unit_model.sv
/*
  Stand-in for the gated units: issues one-cycle access attempts.
  Assumes the bench calls touch from a single process at a time.
*/
`timescale 1ns/1ps

module pcg_unit_model
(
  // Clock
  input wire logic  aclk,
  // Access attempt towards the gate controller
  output logic       unit_access,
  output logic [3:0] unit_select
);
  initial unit_access = 1'b0;
  initial unit_select = 4'h0;

  // One pulse; select is inverted afterwards while access is low
  task automatic touch(input logic [3:0] sel);
    @(posedge aclk);
    unit_access <= 1'b1;
    unit_select <= sel;
    @(posedge aclk);
    unit_access <= 1'b0;
    unit_select <= ~sel;
  endtask
endmodule // pcg_unit_model
